// ---- logic/ppb_bank.sv ----
// Purpose: platform property bank with control and metadata masters and a timebase
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes: board pins pass a two-stage synchroniser before use
//
// Strobed register access and the register offsets were decided locally.
`include "ppb_defs.svh"

module ppb_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

module ppb_bank #(
  parameter logic [511:0] IDENT = 512'h0,
  parameter logic [31:0] TGL_COUNT = 32'h0000_0004,
  parameter logic [31:0] LMP_COUNT = 32'h0000_0004,
  parameter logic [31:0] RGN_COUNT = 32'h0000_0000,
  parameter logic [127:0] RGN_TABLE = 128'h0,
  parameter logic [255:0] NAME_STR = 256'h0,
  parameter logic [255:0] LABEL_STR = 256'h0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // board pins
  input wire logic [31:0] toggle_in,
  output logic [31:0] lamp_out,
  input wire logic [63:0] card_present_in,
  input wire logic pps_generic_in,
  input wire logic pps_gps_in,
  input wire logic pps_ext_in,
  input wire logic power_key_input,
  input wire logic [63:0] chip_serial_in,
  // data plane status
  input wire logic [3:0] bus_error_in,
  input wire logic dp_drop,
  input wire logic [63:0] trace_a_in,
  input wire logic [63:0] trace_b_in,
  input wire logic [63:0] trace_c_in,
  // control-plane master
  output ppb_pkg::ppb_req_t cp_req,
  input wire logic cp_ack,
  input wire logic [31:0] cp_rdata,
  // metadata master
  output ppb_pkg::ppb_req_t md_req,
  input wire logic md_ack,
  input wire logic [31:0] md_rdata,
  // timebase
  output ppb_pkg::ppb_time_t timebase
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [31:0] tgl_s;
  logic [63:0] card_s;
  logic [2:0] pps_s;
  logic pwr_s;
  logic [63:0] ser_s;
  logic [3:0] berr_s;

  ppb_sync #(.W(32)) u_tgl (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(toggle_in),
    .sync_out(tgl_s)
  );
  ppb_sync #(.W(64)) u_card (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(card_present_in),
    .sync_out(card_s)
  );
  ppb_sync #(.W(3)) u_pps (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({pps_ext_in, pps_gps_in, pps_generic_in}),
    .sync_out(pps_s)
  );
  ppb_sync #(.W(1)) u_pwr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(power_key_input),
    .sync_out(pwr_s)
  );
  ppb_sync #(.W(64)) u_ser (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(chip_serial_in),
    .sync_out(ser_s)
  );
  ppb_sync #(.W(4)) u_berr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(bus_error_in),
    .sync_out(berr_s)
  );

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic [15:0] idm_addr_q;
  logic [31:0] lamp_q;
  logic [7:0] pps_sel_q;
  logic [7:0] drop_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      idm_addr_q <= 16'h0000;
    end else if (reg_wr && reg_addr == `PPB_A_IDM_ADDR) begin
      idm_addr_q <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lamp_q <= 32'h0000_0000;
    end else if (reg_wr && reg_addr == `PPB_A_LMP) begin
      lamp_q <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pps_sel_q <= `PPB_PPS_RESET;
    end else if (reg_wr && reg_addr == `PPB_A_PPS_SEL) begin
      pps_sel_q <= reg_wdata[7:0];
    end
  end

  // wraps like a free-running event count
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      drop_q <= 8'h00;
    end else if (dp_drop) begin
      drop_q <= drop_q + 8'h01;
    end
  end

  // ----------------------------------------
  // control-plane and metadata masters
  // ----------------------------------------
  // bridge to planes
  logic [31:0] cp_addr_q;
  logic [31:0] cp_wdata_q;
  logic [31:0] cp_rdata_q;
  logic [31:0] md_addr_q;
  logic [31:0] md_rdata_q;
  ppb_pkg::ppb_state_t cp_st_q;
  ppb_pkg::ppb_state_t md_st_q;
  logic cp_go;
  logic md_go;

  assign cp_go = reg_wr && reg_addr == `PPB_A_CP_CMD && reg_wdata[`PPB_CMD_GO];
  assign md_go = reg_wr && reg_addr == `PPB_A_MD_CMD && reg_wdata[`PPB_CMD_GO];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cp_addr_q <= 32'h0000_0000;
      cp_wdata_q <= 32'h0000_0000;
      md_addr_q <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `PPB_A_CP_ADDR) begin
        cp_addr_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `PPB_A_CP_WDATA) begin
        cp_wdata_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `PPB_A_MD_ADDR) begin
        md_addr_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cp_st_q <= ppb_pkg::PPB_IDLE;
      cp_req <= '0;
      cp_rdata_q <= 32'h0000_0000;
    end else begin
      unique case (cp_st_q)
        ppb_pkg::PPB_IDLE, ppb_pkg::PPB_DONE: begin
          // a new command while busy is ignored
          if (cp_go) begin
            cp_st_q <= ppb_pkg::PPB_WAIT;
            cp_req.valid <= 1'b1;
            cp_req.write <= reg_wdata[`PPB_CMD_WRITE];
            cp_req.addr <= cp_addr_q;
            cp_req.data <= cp_wdata_q;
          end
        end
        ppb_pkg::PPB_WAIT: begin
          if (cp_ack) begin
            cp_st_q <= ppb_pkg::PPB_DONE;
            cp_req.valid <= 1'b0;
            cp_rdata_q <= cp_rdata;
          end
        end
        default: begin
          cp_st_q <= ppb_pkg::PPB_IDLE;
          cp_req.valid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      md_st_q <= ppb_pkg::PPB_IDLE;
      md_req <= '0;
      md_rdata_q <= 32'h0000_0000;
    end else begin
      unique case (md_st_q)
        ppb_pkg::PPB_IDLE, ppb_pkg::PPB_DONE: begin
          if (md_go) begin
            md_st_q <= ppb_pkg::PPB_WAIT;
            md_req.valid <= 1'b1;
            md_req.write <= 1'b0;
            md_req.addr <= md_addr_q;
            md_req.data <= 32'h0000_0000;
          end
        end
        ppb_pkg::PPB_WAIT: begin
          if (md_ack) begin
            md_st_q <= ppb_pkg::PPB_DONE;
            md_req.valid <= 1'b0;
            md_rdata_q <= md_rdata;
          end
        end
        default: begin
          md_st_q <= ppb_pkg::PPB_IDLE;
          md_req.valid <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  logic [1:0] div_q;
  logic pps_mux;

  always_comb begin
    unique case (pps_sel_q)
      `PPB_PPS_GENERIC: pps_mux = pps_s[0];
      `PPB_PPS_GPS: pps_mux = pps_s[1];
      `PPB_PPS_EXT: pps_mux = pps_s[2];
      default: pps_mux = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_q <= 2'b00;
      timebase <= '0;
    end else begin
      timebase.pps <= pps_mux;
      if (div_q == 2'(`PPB_REF_DIV - 1)) begin
        div_q <= 2'b00;
        timebase.tick <= 1'b1;
        timebase.now <= timebase.now + 64'h0000_0000_0000_0001;
      end else begin
        div_q <= div_q + 2'b01;
        timebase.tick <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read side
  // ----------------------------------------
  logic [31:0] rd_d;
  logic [31:0] idm_word;
  logic [63:0] card_mask;
  logic [3:0] sub;

  assign sub = reg_addr[3:0];
  assign card_mask = {{(`PPB_N_CARD - 1){1'b0}}, 1'b1};

  always_comb begin
    idm_word = 32'h0000_0000;
    if (idm_addr_q < 16'(`PPB_N_IDENT)) begin
      idm_word = IDENT[idm_addr_q[3:0]*32 +: 32];
    end
  end

  function automatic logic [31:0] rgn_word(input logic [1:0] i);
    logic [31:0] w;
    w = RGN_TABLE[i*32 +: 32];
    return {w[`PPB_RGN_BUS_HI:`PPB_RGN_BUS_LO], w[`PPB_RGN_OFS_HI:`PPB_RGN_OFS_LO],
            w[`PPB_RGN_SIZE_HI:0]};
  endfunction

  always_comb begin
    rd_d = 32'h0000_0000;
    if (reg_addr[7:4] == `PPB_A_IDENT >> 4) begin
      rd_d = IDENT[sub*32 +: 32];
    end else if (reg_addr[7:3] == `PPB_A_NAME >> 3) begin
      rd_d = NAME_STR[sub[2:0]*32 +: 32];
    end else if (reg_addr[7:3] == `PPB_A_LABEL >> 3) begin
      rd_d = LABEL_STR[sub[2:0]*32 +: 32];
    end else if (reg_addr[7:2] == `PPB_A_RGN >> 2) begin
      rd_d = rgn_word(reg_addr[1:0]);
    end else begin
      unique case (reg_addr)
        `PPB_A_IDM_WORD: rd_d = idm_word;
        `PPB_A_TGL_CNT: rd_d = TGL_COUNT;
        `PPB_A_LMP_CNT: rd_d = LMP_COUNT;
        `PPB_A_RGN_CNT: rd_d = RGN_COUNT;
        `PPB_A_SER_LO: rd_d = ser_s[31:0];
        `PPB_A_SER_HI: rd_d = ser_s[63:32];
        `PPB_A_TGL: rd_d = tgl_s;
        `PPB_A_LMP: rd_d = lamp_q;
        `PPB_A_CARD_LO: rd_d = card_s[31:0] & card_mask[31:0];
        `PPB_A_CARD_HI: rd_d = card_s[63:32] & card_mask[63:32];
        `PPB_A_BUS_ERR: rd_d = {28'h000_0000, berr_s};
        `PPB_A_DROP: rd_d = {24'h00_0000, drop_q};
        `PPB_A_PPS_SEL: rd_d = {24'h00_0000, pps_sel_q};
        `PPB_A_DP_WIDTH: rd_d = `PPB_DP_WIDTH;
        `PPB_A_PWR_KEY: rd_d = {31'h0000_0000, pwr_s};
        `PPB_A_SLOTS: rd_d = `PPB_N_SLOTS;
        8'h28: rd_d = trace_a_in[31:0];
        8'h29: rd_d = trace_a_in[63:32];
        8'h2a: rd_d = trace_b_in[31:0];
        8'h2b: rd_d = trace_b_in[63:32];
        8'h2c: rd_d = trace_c_in[31:0];
        8'h2d: rd_d = trace_c_in[63:32];
        `PPB_A_CP_ADDR: rd_d = cp_addr_q;
        `PPB_A_CP_WDATA: rd_d = cp_wdata_q;
        `PPB_A_CP_STAT: rd_d = {28'h000_0000, md_st_q, cp_st_q};
        `PPB_A_CP_RDATA: rd_d = cp_rdata_q;
        `PPB_A_MD_ADDR: rd_d = md_addr_q;
        `PPB_A_MD_RDATA: rd_d = md_rdata_q;
        `PPB_A_TIME_LO: rd_d = timebase.now[31:0];
        `PPB_A_TIME_HI: rd_d = timebase.now[63:32];
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lamp_out <= 32'h0000_0000;
    end else begin
      lamp_out <= lamp_q;
    end
  end
endmodule

// ---- common/ppb_defs.svh ----
// Purpose: register map, field layout and timing constants of the property bank
// Assumes: word-addressed register port, 8-bit word index
// Notes: included by its bare name
`ifndef PPB_DEFS_SVH
`define PPB_DEFS_SVH
`define PPB_A_IDENT 8'h00
`define PPB_A_IDM_ADDR 8'h10
`define PPB_A_IDM_WORD 8'h11
`define PPB_A_TGL_CNT 8'h12
`define PPB_A_LMP_CNT 8'h13
`define PPB_A_RGN_CNT 8'h14
`define PPB_A_RGN 8'h18
`define PPB_A_SER_LO 8'h1c
`define PPB_A_SER_HI 8'h1d
`define PPB_A_TGL 8'h1e
`define PPB_A_LMP 8'h1f
`define PPB_A_CARD_LO 8'h20
`define PPB_A_CARD_HI 8'h21
`define PPB_A_BUS_ERR 8'h22
`define PPB_A_DROP 8'h23
`define PPB_A_PPS_SEL 8'h24
`define PPB_A_DP_WIDTH 8'h25
`define PPB_A_PWR_KEY 8'h26
`define PPB_A_SLOTS 8'h27
`define PPB_A_TRACE 8'h28
`define PPB_A_CP_ADDR 8'h2e
`define PPB_A_CP_WDATA 8'h2f
`define PPB_A_CP_CMD 8'h30
`define PPB_A_CP_STAT 8'h31
`define PPB_A_CP_RDATA 8'h32
`define PPB_A_MD_ADDR 8'h33
`define PPB_A_MD_CMD 8'h34
`define PPB_A_MD_RDATA 8'h35
`define PPB_A_TIME_LO 8'h36
`define PPB_A_TIME_HI 8'h37
`define PPB_A_NAME 8'h40
`define PPB_A_LABEL 8'h48
`define PPB_N_IDENT 16
`define PPB_N_RGN 4
`define PPB_N_CARD 64
`define PPB_N_SLOTS 32'h0000_0001
`define PPB_DP_WIDTH 32'h0000_0001
`define PPB_PPS_GENERIC 8'h00
`define PPB_PPS_GPS 8'h01
`define PPB_PPS_EXT 8'h02
`define PPB_PPS_RESET 8'h00
`define PPB_RGN_BUS_HI 31
`define PPB_RGN_BUS_LO 28
`define PPB_RGN_OFS_HI 27
`define PPB_RGN_OFS_LO 14
`define PPB_RGN_SIZE_HI 13
`define PPB_PAGE_SHIFT 12
`define PPB_SYS_MHZ 200
`define PPB_REF_MHZ 100
`define PPB_REF_DIV (`PPB_SYS_MHZ / `PPB_REF_MHZ)
`define PPB_NAME_CHARS 31
`define PPB_LABEL_CHARS 32
`define PPB_CMD_GO 0
`define PPB_CMD_WRITE 1
`endif

// ---- common/ppb_pkg.sv ----
// Purpose: types shared by the property bank and its neighbours
// Assumes: constants come from ppb_defs.svh
// Notes: the state encodings and field widths are held here
package ppb_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] data;
  } ppb_req_t;
  typedef struct packed {
    logic tick;
    logic pps;
    logic [63:0] now;
  } ppb_time_t;
  typedef enum logic [1:0] {
    PPB_IDLE = 2'b00,
    PPB_WAIT = 2'b01,
    PPB_DONE = 2'b11
  } ppb_state_t;
endpackage

// ---- tb/ppb_bank_monitor.sv ----
// Purpose: port checks of the property bank
// Assumes: one clock, bound to ppb_bank
// Notes: bind lives in the bench top file
`include "ppb_defs.svh"
module ppb_bank_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] lamp_out,
  // masters and timebase
  input wire ppb_pkg::ppb_req_t cp_req,
  input wire logic cp_ack,
  input wire ppb_pkg::ppb_req_t md_req,
  input wire logic md_ack,
  input wire ppb_pkg::ppb_time_t timebase
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ----
  // checks
  // ----
  rdata_quiet_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");
  lamp_readback_a:
    assert property (reg_rd && reg_addr == `PPB_A_LMP |=> reg_rdata == lamp_out)
    else $error("lamp readback");
  lamp_write_a:
    assert property (reg_wr && reg_addr == `PPB_A_LMP |-> ##2 lamp_out == $past(reg_wdata, 2))
    else $error("lamp write");
  cp_start_a:
    assert property (reg_wr && reg_addr == `PPB_A_CP_CMD && reg_wdata[0] && !cp_req.valid
      |=> cp_req.valid && cp_req.write == $past(reg_wdata[1])) else $error("cp start");
  cp_hold_a:
    assert property (cp_req.valid && !cp_ack |=> cp_req.valid && $stable(cp_req))
    else $error("cp hold");
  cp_release_a:
    assert property (cp_req.valid && cp_ack |=> !cp_req.valid) else $error("cp release");
  md_start_a:
    assert property (reg_wr && reg_addr == `PPB_A_MD_CMD && reg_wdata[0] && !md_req.valid
      |=> md_req.valid && !md_req.write) else $error("md start");
  md_release_a:
    assert property (md_req.valid && md_ack |=> !md_req.valid) else $error("md release");
  tick_pace_a:
    assert property (timebase.tick |=> !timebase.tick ##1 timebase.tick) else $error("tick");
  time_step_a:
    assert property ($past(nrst) && $changed(timebase.now)
      |-> timebase.now == $past(timebase.now) + 64'h1) else $error("time step");
  cover property (cp_req.valid && cp_ack && cp_req.write);
  cover property (md_req.valid && md_ack);
  cover property (reg_wr && reg_addr == `PPB_A_LMP);
endmodule

// ---- tb/ppb_far_model.sv ----
// Purpose: far-side slave for one master port
// Assumes: request holds until the cycle after ack
// Notes: read data = last write data xor address
module ppb_far_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // channel
  input wire logic [3:0] delay,
  input wire ppb_pkg::ppb_req_t req,
  output logic ack,
  output logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_q;
  logic busy_q;
  logic [31:0] store_q;
  // ----
  // answer
  // ----
  always_ff @(posedge sys_clk) begin
    ack <= 1'b0;
    // data not held outside the ack cycle
    rdata <= ~rdata;
    if (!nrst) begin
      wait_q <= 4'h0;
      busy_q <= 1'b0;
      store_q <= 32'h0;
      rdata <= 32'h0;
    end else if (req.valid && !busy_q) begin
      if (wait_q == delay) begin
        ack <= 1'b1;
        busy_q <= 1'b1;
        rdata <= store_q ^ req.addr;
        if (req.write) begin
          store_q <= req.data;
        end
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else if (!req.valid) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end
  end
endmodule

// ---- tb/ppb_bank_test.sv ----
// Purpose: self-checking bench of the property bank
// Assumes: two far-side models, slow and prompt
// Notes: register sequences with expected values
`include "ppb_defs.svh"
module ppb_bank_test;
  timeunit 1ns;
  timeprecision 100ps;
  // identifier values are arbitrary
  function automatic logic [511:0] mk_ident();
    for (int i = 0; i < 16; i++) begin
      mk_ident[32*i+:32] = 32'h0a00_0000 + 32'(i);
    end
  endfunction
  localparam logic [511:0] ID_V = mk_ident();
  localparam logic [31:0] RGN0 = {4'h2, 14'h0003, 14'h0010};
  // name and label words are arbitrary
  localparam logic [255:0] NM_V = {32'h7072_7373, 224'h0};
  localparam logic [255:0] LB_V = {192'h0, 32'h6c62_6c31, 32'h0};
  logic sys_clk, nrst, reg_wr, reg_rd, power_key_input, dp_drop, cp_ack, md_ack;
  logic [2:0] pps;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, toggle_in, lamp_out, cp_rdata, md_rdata, rv, t0;
  logic [63:0] card_present_in, chip_serial_in, trace_v;
  logic [3:0] bus_error_in;
  ppb_pkg::ppb_req_t cp_req, md_req;
  ppb_pkg::ppb_time_t timebase;
  int err_count, samples_checked;
  ppb_bank #(.IDENT(ID_V), .TGL_COUNT(32'h0000_0006), .RGN_COUNT(32'h0000_0001),
    .RGN_TABLE({96'h0, RGN0}), .NAME_STR(NM_V), .LABEL_STR(LB_V)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .toggle_in(toggle_in),
    .lamp_out(lamp_out), .card_present_in(card_present_in), .pps_generic_in(pps[0]),
    .pps_gps_in(pps[1]), .pps_ext_in(pps[2]), .power_key_input(power_key_input),
    .chip_serial_in(chip_serial_in), .bus_error_in(bus_error_in), .dp_drop(dp_drop),
    .trace_a_in(trace_v), .trace_b_in(~trace_v),
    .trace_c_in({trace_v[31:0], trace_v[63:32]}), .cp_req(cp_req),
    .cp_ack(cp_ack), .cp_rdata(cp_rdata), .md_req(md_req), .md_ack(md_ack),
    .md_rdata(md_rdata), .timebase(timebase));
  ppb_far_model i_cp (.sys_clk(sys_clk), .nrst(nrst), .delay(4'h7), .req(cp_req),
    .ack(cp_ack), .rdata(cp_rdata));
  ppb_far_model i_md (.sys_clk(sys_clk), .nrst(nrst), .delay(4'h0), .req(md_req),
    .ack(md_ack), .rdata(md_rdata));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // let an edge pass so a following write never re-raises the strobe in this step
    @(posedge sys_clk);
  endtask
  // data stand one cycle only, so sample 1 ns after the edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task automatic poll(input int sh);
    int n;
    n = 0;
    rv = 32'h0;
    while (rv[sh+:2] !== 2'b11 && n < 40) begin
      rd(`PPB_A_CP_STAT, rv);
      n++;
    end
    chk(32'(rv[sh+:2]), 32'h3);
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----
  // run
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    toggle_in = 32'h0;
    card_present_in = '1;
    pps = 3'h0;
    power_key_input = 1'b1;
    chip_serial_in = 64'h0123_4567_89ab_cdef;
    bus_error_in = 4'h9;
    dp_drop = 1'b0;
    trace_v = 64'hfeed_0001_c0de_0002;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rc(`PPB_A_PPS_SEL, 32'h0);
    rc(`PPB_A_IDENT + 8'h0f, ID_V[511:480]);
    wr(`PPB_A_IDM_ADDR, 32'h0000_0005);
    rc(`PPB_A_IDM_WORD, ID_V[191:160]);
    wr(`PPB_A_IDM_ADDR, 32'h0000_0010);
    rc(`PPB_A_IDM_WORD, 32'h0);
    wr(`PPB_A_TGL_CNT, 32'hffff_ffff);
    rc(`PPB_A_TGL_CNT, 32'h0000_0006);
    rc(8'h3f, 32'h0);
    rc(`PPB_A_RGN, {4'h2, 14'(32'h0000_3000 >> 12), 14'(32'h0001_0000 >> 12)});
    rc(`PPB_A_SER_LO, 32'h89ab_cdef);
    rc(`PPB_A_SER_HI, 32'h0123_4567);
    rc(`PPB_A_CARD_LO, 32'h1);
    rc(`PPB_A_CARD_HI, 32'h0);
    rc(`PPB_A_SLOTS, 32'h1);
    rc(`PPB_A_DP_WIDTH, 32'h1);
    rc(`PPB_A_BUS_ERR, 32'h9);
    rc(`PPB_A_PWR_KEY, 32'h1);
    rc(`PPB_A_TRACE, 32'hc0de_0002);
    rc(`PPB_A_TRACE + 8'h03, 32'h0112_fffe);
    rc(`PPB_A_TRACE + 8'h04, 32'hfeed_0001);
    rc(`PPB_A_NAME + 8'h07, 32'h7072_7373);
    rc(`PPB_A_LABEL + 8'h01, 32'h6c62_6c31);
    rc(`PPB_A_LABEL + 8'h07, 32'h0);
    rc(`PPB_A_LMP_CNT, 32'h0000_0004);
    rc(`PPB_A_RGN_CNT, 32'h0000_0001);
    power_key_input <= 1'b0;
    dp_drop <= 1'b1;
    repeat (3) @(posedge sys_clk);
    dp_drop <= 1'b0;
    rc(`PPB_A_PWR_KEY, 32'h0);
    rc(`PPB_A_DROP, 32'h3);
    for (int k = 0; k < 2; k++) begin
      toggle_in <= 32'h0000_00a0 << k;
      repeat (3) @(posedge sys_clk);
      rc(`PPB_A_TGL, 32'h0000_00a0 << k);
    end
    wr(`PPB_A_LMP, 32'h5a5a_0f0f);
    wr(`PPB_A_LMP, 32'h0000_0003);
    rc(`PPB_A_LMP, 32'h0000_0003);
    chk(lamp_out, 32'h0000_0003);
    for (int k = 0; k < 4; k++) begin
      wr(`PPB_A_PPS_SEL, 32'(k));
      pps <= 3'h7 ^ (3'h1 << k);
      repeat (6) @(posedge sys_clk);
      chk(32'(timebase.pps), 32'h0);
      pps <= 3'h7;
      repeat (6) @(posedge sys_clk);
      chk(32'(timebase.pps), (k < 3) ? 32'h1 : 32'h0);
    end
    wr(`PPB_A_CP_ADDR, 32'h0000_0044);
    wr(`PPB_A_CP_WDATA, 32'h1234_5678);
    wr(`PPB_A_CP_CMD, 32'h0000_0003);
    poll(0);
    wr(`PPB_A_CP_ADDR, 32'h0000_0040);
    wr(`PPB_A_CP_CMD, 32'h0000_0001);
    poll(0);
    rc(`PPB_A_CP_RDATA, 32'h1234_5638);
    wr(`PPB_A_MD_ADDR, 32'h0000_0009);
    wr(`PPB_A_MD_CMD, 32'h0000_0001);
    poll(2);
    rc(`PPB_A_MD_RDATA, 32'h0000_0009);
    // two reads two edges apart see exactly one tick
    rd(`PPB_A_TIME_LO, t0);
    rd(`PPB_A_TIME_LO, rv);
    chk(rv - t0, 32'h0000_0001);
    // mid-run reset returns the stores to their reset values
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rc(`PPB_A_LMP, 32'h0);
    rc(`PPB_A_PPS_SEL, 32'h0);
    rc(`PPB_A_CP_STAT, 32'h0);
    chk(lamp_out, 32'h0);
    give_verdict();
  end
endmodule
bind ppb_bank ppb_bank_monitor i_mon (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lamp_out(lamp_out),
  .cp_req(cp_req), .cp_ack(cp_ack), .md_req(md_req), .md_ack(md_ack), .timebase(timebase));
